// ==== bench/rbc_flash_model.sv ====
`timescale 1ns/1ps
module rbc_flash_model
   import rbc_pkg::*;
(
   input  wire logic                 i_clk_sys,
   input  wire logic [31:0]          i_word,
   input  wire logic [7:0]           i_lat,
   input  wire rbc_pkg::rbc_rd_req_t i_rd_req,
   output rbc_pkg::rbc_rd_rsp_t      o_rd_rsp
);
   logic [7:0] cnt_reg = 8'h00;
   initial o_rd_rsp = '0;
   always @(posedge i_clk_sys) begin
      o_rd_rsp.valid <= 1'b0;
      // released bus never keeps the old word
      o_rd_rsp.data  <= ~o_rd_rsp.data;
      if (i_rd_req.req && i_rd_req.addr == 24'h00_0004) begin
         cnt_reg <= i_lat + 8'h01;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
      if (cnt_reg == 8'h01) begin
         o_rd_rsp.valid <= 1'b1;
         o_rd_rsp.data  <= i_word;
      end
   end
endmodule // rbc_flash_model

// ==== bench/rbc_loader_sva.sv ====
`timescale 1ns/1ps
module rbc_loader_sva
   import rbc_pkg::*;
#(
   parameter longint unsigned POR_HOLD = 20
) (
   input wire logic                 i_clk_sys,
   input wire logic                 i_rst_b,
   input wire logic [3:0]           i_chip_select_n,
   input wire logic [3:0]           i_comb_join,
   input wire rbc_pkg::rbc_rd_rsp_t i_rd_rsp,
   input wire rbc_pkg::rbc_rd_req_t o_rd_req,
   input wire logic                 o_combined_chip_select_n,
   input wire logic                 o_power_on_reset_n,
   input wire rbc_pkg::rbc_straps_t o_boot_straps,
   input wire rbc_pkg::rbc_mode_t   o_boot_mode,
   input wire logic [15:0]          o_bus_timing_config_zero,
   input wire logic [31:0]          o_start_pc,
   input wire logic                 o_start_valid
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   sequence s_ext_done;
      $rose(o_start_valid) && o_boot_mode == RBC_MODE_EXT;
   endsequence
   a_por_hold: assert property (
      $rose(o_power_on_reset_n) |-> !$past(o_power_on_reset_n, POR_HOLD))
      else $error("power-on reset released too early");
   a_boot_follows: assert property (
      $rose(o_power_on_reset_n) |=> o_start_valid || o_rd_req.req)
      else $error("boot did not start after reset release");
   a_req_fields: assert property (
      o_rd_req.req |-> o_rd_req.addr == CFG_WORD_ADDR
         && o_rd_req.timing == BTC_DEFAULT && o_boot_mode == RBC_MODE_EXT)
      else $error("config read has wrong address, timing or mode");
   a_req_pulse: assert property (
      o_rd_req.req |=> !o_rd_req.req [*2])
      else $error("config read requested twice");
   a_timing_load: assert property (
      s_ext_done |-> o_start_pc == PC_EXT_MEM
         && o_bus_timing_config_zero == $past(i_rd_rsp.data[15:0]))
      else $error("timing word or start address wrong");
   a_loader_pc: assert property (
      o_start_valid |-> o_start_pc == ((o_boot_mode == RBC_MODE_EXT)
         ? PC_EXT_MEM : PC_LOADER))
      else $error("start address does not match boot mode");
   a_mode_decode: assert property (
      o_start_valid && o_boot_straps.hw_boot_config < 3'h4 |->
         o_boot_mode == rbc_mode_t'(o_boot_straps.hw_boot_config))
      else $error("boot mode does not match captured code");
   a_straps_held: assert property (
      o_start_valid && $past(o_start_valid) |-> $stable(o_boot_straps))
      else $error("captured boot options changed");
   a_comb_and: assert property (
      $past(i_rst_b) && $past(i_rst_b, 2) |-> o_combined_chip_select_n
         == &($past(i_chip_select_n, 2) | ~i_comb_join))
      else $error("combined select is not the and of joined selects");
endmodule // rbc_loader_sva
bind rbc_loader rbc_loader_sva #(.POR_HOLD(POR_HOLD)) i_sva (.*);

// ==== bench/rbc_loader_tb_top.sv ====
`timescale 1ns/1ps
module rbc_loader_tb_top;
   import rbc_pkg::*;
   localparam int HOLD = 20;
   logic        clk_sys = 1'b0, rst_b = 1'b0, supply_good = 1'b0;
   logic        alt_boot_n = 1'b1, sw_boot_en = 1'b0;
   rbc_straps_t std_straps = '0, alt_straps = '0, sw_straps = '0;
   rbc_straps_t boot_straps;
   logic [3:0]  cs_n = 4'hf, join_en = 4'h0;
   logic [31:0] word = 32'h0, start_pc;
   logic [7:0]  lat = 8'h00;
   logic [15:0] btc;
   logic        comb_n, por_n, start_valid;
   rbc_rd_req_t rd_req;
   rbc_rd_rsp_t rd_rsp;
   rbc_mode_t   boot_mode;
   int          errors = 0, check_count = 0;
   rbc_loader #(.POR_HOLD(HOLD)) i_dut (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
      .i_supply_good(supply_good), .i_alt_boot_n(alt_boot_n),
      .i_std_straps(std_straps), .i_alt_straps(alt_straps),
      .i_sw_boot_en(sw_boot_en), .i_sw_straps(sw_straps), .o_rd_req(rd_req),
      .i_rd_rsp(rd_rsp), .i_chip_select_n(cs_n), .i_comb_join(join_en),
      .o_combined_chip_select_n(comb_n), .o_power_on_reset_n(por_n),
      .o_boot_straps(boot_straps), .o_boot_mode(boot_mode),
      .o_bus_timing_config_zero(btc), .o_start_pc(start_pc),
      .o_start_valid(start_valid));
   rbc_flash_model i_flash (.i_clk_sys(clk_sys), .i_word(word), .i_lat(lat),
      .i_rd_req(rd_req), .o_rd_rsp(rd_rsp));
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic boot;
      int n;
      rst_b = 1'b0;
      supply_good = 1'b0;
      step(3);
      rst_b = 1'b1;
      supply_good = 1'b1;
      for (n = 0; n < 100 && por_n !== 1'b1; n++) step(1);
      chk(32'(n >= HOLD && n <= HOLD + 4), 32'h1);
      for (n = 0; n < 100 && start_valid !== 1'b1; n++) step(1);
      if (start_valid !== 1'b1) begin
         errors++;
         end_of_test;
      end
   endtask
   task automatic t_loaders;
      alt_straps = {CFG_EXT_MEM, 2'b11};
      for (int c = 0; c < 3; c++) begin
         std_straps = {3'(c), 2'b00};
         boot;
         chk(32'(boot_mode), 32'(c));
         chk(start_pc, PC_LOADER);
         chk(32'(boot_straps), 32'(std_straps));
      end
      std_straps = {3'h6, 2'b00};
      boot;
      chk(32'(boot_mode), 32'(RBC_MODE_OTHER));
      chk(start_pc, PC_LOADER);
      $display("test loaders done");
   endtask
   task automatic t_ext_boot;
      alt_boot_n = 1'b0;
      word = 32'h5a5a_1234;
      lat = 8'h09;
      std_straps = '0;
      boot;
      chk(32'(boot_mode), 32'(RBC_MODE_EXT));
      chk(32'(btc), 32'h0000_1234);
      chk(start_pc, PC_EXT_MEM);
      alt_boot_n = 1'b1;
      $display("test ext boot done");
   endtask
   task automatic t_sw_override;
      std_straps = {CFG_EXT_MEM, 2'b00};
      sw_straps = {CFG_CAN_BOOT, 2'b01};
      sw_boot_en = 1'b1;
      boot;
      chk(32'(boot_mode), 32'(RBC_MODE_CAN));
      std_straps = '0;
      sw_straps = '0;
      step(5);
      chk(32'(boot_straps), 32'({CFG_CAN_BOOT, 2'b01}));
      sw_boot_en = 1'b0;
      $display("test sw override done");
   endtask
   task automatic t_comb;
      for (int k = 0; k < 16; k++) begin
         cs_n = 4'(k);
         join_en = 4'(k * 7);
         step(3);
         chk(32'(comb_n), 32'(&(cs_n | ~join_en)));
      end
      $display("test combined select done");
   endtask
   initial begin
      step(3);
      t_loaders;
      t_ext_boot;
      t_sw_override;
      t_comb;
      end_of_test;
   end
endmodule // rbc_loader_tb_top

// ==== verilog/rbc_loader.sv ====
`timescale 1ns/1ps
module rbc_loader #(
   parameter longint unsigned POR_HOLD = rbc_pkg::POR_HOLD_CYC
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_b,
   input  wire logic                 i_supply_good,
   input  wire logic                 i_alt_boot_n,
   input  wire rbc_pkg::rbc_straps_t i_std_straps,
   input  wire rbc_pkg::rbc_straps_t i_alt_straps,
   input  wire logic                 i_sw_boot_en,
   input  wire rbc_pkg::rbc_straps_t i_sw_straps,
   output rbc_pkg::rbc_rd_req_t      o_rd_req,
   input  wire rbc_pkg::rbc_rd_rsp_t i_rd_rsp,
   input  wire logic [3:0]           i_chip_select_n,
   input  wire logic [3:0]           i_comb_join,
   output logic                      o_combined_chip_select_n,
   output logic                      o_power_on_reset_n,
   output rbc_pkg::rbc_straps_t      o_boot_straps,
   output rbc_pkg::rbc_mode_t        o_boot_mode,
   output logic [15:0]               o_bus_timing_config_zero,
   output logic [31:0]               o_start_pc,
   output logic                      o_start_valid
);
   import rbc_pkg::*;

   typedef enum logic [2:0] {
      ST_POR_HOLD,
      ST_CAPTURE,
      ST_FETCH,
      ST_WAIT,
      ST_RUN
   } rbc_state_t;

   function automatic rbc_mode_t decode_mode(input logic [2:0] cfg);
      case (cfg)
         CFG_ASYNC_BOOT: decode_mode = RBC_MODE_ASYNC;
         CFG_CAN_BOOT:   decode_mode = RBC_MODE_CAN;
         CFG_SYNC_BOOT:  decode_mode = RBC_MODE_SYNC;
         CFG_EXT_MEM:    decode_mode = RBC_MODE_EXT;
         default:        decode_mode = RBC_MODE_OTHER;
      endcase
   endfunction

   // pins are asynchronous to the core clock
   logic        supply_s1_reg;
   logic        supply_s2_reg;
   logic        alt_s1_reg;
   logic        alt_s2_reg;
   rbc_straps_t std_s1_reg;
   rbc_straps_t std_s2_reg;
   rbc_straps_t alt_str_s1_reg;
   rbc_straps_t alt_str_s2_reg;
   logic [3:0]  cs_s1_reg;
   logic [3:0]  cs_s2_reg;

   rbc_state_t      state_reg;
   rbc_state_t      state_next;
   logic [31:0]     hold_cnt_reg;
   logic            por_n_reg;
   rbc_straps_t     straps_reg;
   rbc_mode_t       mode_reg;
   logic [15:0]     btc_reg;
   logic [31:0]     pc_reg;
   logic            start_reg;
   logic            req_reg;

   wire rbc_straps_t pin_sel;
   wire rbc_straps_t eff_sel;
   wire rbc_mode_t   sel_mode;
   wire logic        hold_done;
   wire logic [3:0]  cs_joined;

   assign pin_sel   = alt_s2_reg ? std_s2_reg : alt_str_s2_reg;
   assign eff_sel   = i_sw_boot_en ? i_sw_straps : pin_sel;
   assign sel_mode  = decode_mode(eff_sel.hw_boot_config);
   assign hold_done = 64'(hold_cnt_reg) >= (POR_HOLD - 64'd1);
   assign cs_joined = cs_s2_reg | ~i_comb_join;

   always_ff @(posedge i_clk_sys) begin
      supply_s1_reg  <= i_supply_good;
      supply_s2_reg  <= supply_s1_reg;
      alt_s1_reg     <= i_alt_boot_n;
      alt_s2_reg     <= alt_s1_reg;
      std_s1_reg     <= i_std_straps;
      std_s2_reg     <= std_s1_reg;
      alt_str_s1_reg <= i_alt_straps;
      alt_str_s2_reg <= alt_str_s1_reg;
      cs_s1_reg      <= i_chip_select_n;
      cs_s2_reg      <= cs_s1_reg;
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_POR_HOLD: begin
            if (supply_s2_reg && hold_done) begin
               state_next = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            state_next = (sel_mode == RBC_MODE_EXT) ? ST_FETCH : ST_RUN;
         end
         ST_FETCH: begin
            state_next = ST_WAIT;
         end
         ST_WAIT: begin
            if (i_rd_rsp.valid) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_POR_HOLD;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         state_reg <= ST_POR_HOLD;
      end else if (!supply_s2_reg) begin
         state_reg <= ST_POR_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   // hold counter restarts whenever supplies drop
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || !supply_s2_reg) begin
         hold_cnt_reg <= '0;
      end else if (state_reg == ST_POR_HOLD && !hold_done) begin
         hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || !supply_s2_reg) begin
         por_n_reg <= 1'b0;
      end else if (state_reg == ST_POR_HOLD && hold_done) begin
         por_n_reg <= 1'b1;
      end
   end

   // captured exactly once at release; later pin changes are ignored
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         straps_reg <= '0;
         mode_reg   <= RBC_MODE_OTHER;
      end else if (state_reg == ST_CAPTURE) begin
         straps_reg <= eff_sel;
         mode_reg   <= sel_mode;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         req_reg <= 1'b0;
      end else begin
         req_reg <= (state_next == ST_FETCH);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         btc_reg <= BTC_RESET_VAL;
      end else if (state_reg == ST_WAIT && i_rd_rsp.valid) begin
         btc_reg <= i_rd_rsp.data[BTC_FIELD_LSB +: BTC_FIELD_W];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         pc_reg    <= PC_RESET_VAL;
         start_reg <= 1'b0;
      end else if (state_reg == ST_CAPTURE && sel_mode != RBC_MODE_EXT) begin
         // unknown codes fall back to the loader entry point
         pc_reg    <= PC_LOADER;
         start_reg <= 1'b1;
      end else if (state_reg == ST_WAIT && i_rd_rsp.valid) begin
         pc_reg    <= PC_EXT_MEM;
         start_reg <= 1'b1;
      end
   end

   assign o_rd_req.req    = req_reg;
   assign o_rd_req.addr   = CFG_WORD_ADDR;
   assign o_rd_req.timing = BTC_DEFAULT;

   assign o_combined_chip_select_n = &cs_joined;
   assign o_power_on_reset_n       = por_n_reg;
   assign o_boot_straps            = straps_reg;
   assign o_boot_mode              = mode_reg;
   assign o_bus_timing_config_zero = btc_reg;
   assign o_start_pc               = pc_reg;
   assign o_start_valid            = start_reg;

endmodule // rbc_loader

// ==== verilog/rbc_pkg.sv ====
package rbc_pkg;

   localparam int unsigned CLK_MHZ       = 200;
   // power-on hold after supplies settle, in ms as printed
   localparam int unsigned POR_HOLD_MS   = 200;
   localparam longint unsigned POR_HOLD_CYC =
      longint'(POR_HOLD_MS) * 1000 * CLK_MHZ;

   localparam logic [2:0]  CFG_EXT_MEM   = 3'h3;
   localparam logic [2:0]  CFG_ASYNC_BOOT = 3'h0;
   localparam logic [2:0]  CFG_CAN_BOOT   = 3'h1;
   localparam logic [2:0]  CFG_SYNC_BOOT  = 3'h2;

   localparam logic [31:0] PC_EXT_MEM    = 32'ha000_0000;
   localparam logic [31:0] PC_LOADER     = 32'hd400_0000;
   localparam logic [31:0] PC_RESET_VAL  = 32'h0000_0000;

   localparam logic [23:0] CFG_WORD_ADDR = 24'h00_0004;
   // default timing for the blind read: slowest, widest-margin setting
   localparam logic [15:0] BTC_DEFAULT   = 16'hffff;
   localparam logic [15:0] BTC_RESET_VAL = 16'hffff;
   // timing-related bits of the fetched word
   localparam int unsigned BTC_FIELD_LSB = 0;
   localparam int unsigned BTC_FIELD_W   = 16;

   typedef enum logic [2:0] {
      RBC_MODE_ASYNC,
      RBC_MODE_CAN,
      RBC_MODE_SYNC,
      RBC_MODE_EXT,
      RBC_MODE_OTHER
   } rbc_mode_t;

   typedef struct packed {
      logic [2:0] hw_boot_config;
      logic       break_input;
      logic       test_select_pin;
   } rbc_straps_t;

   typedef struct packed {
      logic        req;
      logic [23:0] addr;
      logic [15:0] timing;
   } rbc_rd_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } rbc_rd_rsp_t;

endpackage
